// ---- core/sbcct_regs.vh ----
// Register map, field positions, reset values and counts of the 16-bit capture/compare timer
//
// How it works
// - Any enabled timer flag raises the one shared request while the processor mask is clear.
// - Capture A flag also sets when the counter restarts at period end in waveform mode.
// - Compare flags never set by hardware while waveform mode is active.
// - Capture enable bit 7 lets either capture flag request an interrupt.
// - Compare enable bit 6 lets either compare flag request an interrupt.
// - Rollover enable bit 5 lets the rollover flag request an interrupt.
// - Writing a force bit copies that channel's level to its enabled pin at once.
// - Level B drives pin B on compare B, or pin A in single pulse and waveform modes.
// - Edge bit A picks falling (0) or rising (1) capture edge on pin A.
// - Level A drives enabled pin A whenever the counter matches compare A.
// - Pin enables only route outputs; compare matching and flags run regardless.
// - Single pulse mode: active edge on pin A starts one pulse, length from compare A.
// - Waveform mode: pin A repeats, compare A sets pulse length, compare B period.
// - Clock select 00 divides by 4, 01 by 2, 10 by 8, 11 external pin.
// - External clock selected without an external pin stops the counter.
// - Edge bit B picks falling (0) or rising (1) capture edge on pin B.
// - External edge bit picks falling (0) or rising (1) counting edge.
// - Capture A flag clears by status read then access to capture A low byte.
// - Compare A flag sets on match outside single pulse and waveform modes, clears by status read then compare A low access.
// - Rollover flag sets at FFFF to 0000; only status read then counter low byte access clears it.
// - Capture B and compare B flags clear by status read then their low byte access.
// - Freeze bit stops prescaler and counter and disables pins; registers stay usable.
// - In waveform mode the compare B event reloads the counter with FFFC.
// - In waveform mode new compare values take effect only at the period end.
// - After a compare high byte write, that compare is inhibited until its low write.
`ifndef SBCCT_REGS_VH
`define SBCCT_REGS_VH

// ============================================================
// Register offsets
`define SBCCT_OFS_CTRL_TWO 8'h51
`define SBCCT_OFS_CTRL_ONE 8'h52
`define SBCCT_OFS_STATUS 8'h53
`define SBCCT_OFS_CAP_A_HI 8'h54
`define SBCCT_OFS_CAP_A_LO 8'h55
`define SBCCT_OFS_CMP_A_HI 8'h56
`define SBCCT_OFS_CMP_A_LO 8'h57
`define SBCCT_OFS_CNT_HI 8'h58
`define SBCCT_OFS_CNT_LO 8'h59
`define SBCCT_OFS_ALT_HI 8'h5a
`define SBCCT_OFS_ALT_LO 8'h5b
`define SBCCT_OFS_CAP_B_HI 8'h5c
`define SBCCT_OFS_CAP_B_LO 8'h5d
`define SBCCT_OFS_CMP_B_HI 8'h5e
`define SBCCT_OFS_CMP_B_LO 8'h5f

// ============================================================
// Control one fields
`define SBCCT_C1_CAP_IE 7
`define SBCCT_C1_CMP_IE 6
`define SBCCT_C1_ROLL_IE 5
`define SBCCT_C1_FORCE_B 4
`define SBCCT_C1_FORCE_A 3
`define SBCCT_C1_LEVEL_B 2
`define SBCCT_C1_EDGE_A 1
`define SBCCT_C1_LEVEL_A 0

// ============================================================
// Control two fields
`define SBCCT_C2_PIN_A_EN 7
`define SBCCT_C2_PIN_B_EN 6
`define SBCCT_C2_SINGLE 5
`define SBCCT_C2_WAVE 4
`define SBCCT_C2_CLK_HI 3
`define SBCCT_C2_CLK_LO 2
`define SBCCT_C2_EDGE_B 1
`define SBCCT_C2_EXT_EDGE 0

// ============================================================
// Status fields
`define SBCCT_ST_CAP_A 7
`define SBCCT_ST_CMP_A 6
`define SBCCT_ST_ROLL 5
`define SBCCT_ST_CAP_B 4
`define SBCCT_ST_CMP_B 3
`define SBCCT_ST_FREEZE 2

// ============================================================
// Reset and reload values, prescaler last counts
`define SBCCT_CTRL_RESET 8'h00
`define SBCCT_CNT_RELOAD 16'hfffc
`define SBCCT_CNT_TOP 16'hffff
`define SBCCT_CMP_RESET 16'h8000
`define SBCCT_CLK_DIV4 2'h0
`define SBCCT_CLK_DIV2 2'h1
`define SBCCT_CLK_DIV8 2'h2
`define SBCCT_CLK_EXT 2'h3
`define SBCCT_LAST_DIV4 3'h3
`define SBCCT_LAST_DIV2 3'h1
`define SBCCT_LAST_DIV8 3'h7

`endif

// ---- core/sbcct_timer.v ----
// 16-bit free-running timer with two captures, two compares, single pulse and waveform modes
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "sbcct_regs.vh"

module sbcct_timer #(
  parameter EXT_CLOCK_PRESENT = 1
) (
  input wire REF_CLK,
  input wire SYS_RST,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [7:0] REG_RDATA,
  input wire CAPTURE_PIN_A,
  input wire CAPTURE_PIN_B,
  input wire EXT_CLOCK_PIN,
  input wire CPU_IRQ_MASK,
  output reg TIMER_IRQ,
  output reg COMPARE_PIN_A,
  output reg COMPARE_PIN_A_OE,
  output reg COMPARE_PIN_B,
  output reg COMPARE_PIN_B_OE
);

  // ============================================================
  // Helper functions

  // Edge detector shared by both capture pins and the external clock
  function edge_seen;
    input prev;
    input cur;
    input rising;
    begin
      edge_seen = rising ? (~prev & cur) : (prev & ~cur);
    end
  endfunction

  // Last prescaler count for each internal division
  function [2:0] presc_last;
    input [1:0] sel;
    begin
      case (sel)
        `SBCCT_CLK_DIV2: presc_last = `SBCCT_LAST_DIV2;
        `SBCCT_CLK_DIV8: presc_last = `SBCCT_LAST_DIV8;
        default: presc_last = `SBCCT_LAST_DIV4;
      endcase
    end
  endfunction

  // ============================================================
  // State
  reg [7:0] ctrl_one;
  reg [7:0] ctrl_two;
  reg timer_freeze;
  reg capture_a_flag;
  reg capture_b_flag;
  reg compare_a_flag;
  reg compare_b_flag;
  reg rollover_flag;
  reg [4:0] clear_armed;
  reg [15:0] counter;
  reg [2:0] presc;
  reg [15:0] capture_value_a;
  reg [15:0] capture_value_b;
  reg [15:0] compare_value_a;
  reg [15:0] compare_value_b;
  reg [15:0] active_cmp_a;
  reg [15:0] active_cmp_b;
  reg inhibit_a;
  reg inhibit_b;
  reg cap_a_prev;
  reg cap_b_prev;
  reg ext_prev;
  reg level_a;
  reg level_b;

  // ============================================================
  // Decode of the register port
  wire wr_c1 = REG_WR && (REG_ADDR == `SBCCT_OFS_CTRL_ONE);
  wire wr_c2 = REG_WR && (REG_ADDR == `SBCCT_OFS_CTRL_TWO);
  wire wr_st = REG_WR && (REG_ADDR == `SBCCT_OFS_STATUS);
  wire rd_st = REG_RD && (REG_ADDR == `SBCCT_OFS_STATUS);
  wire wr_cmp_a_hi = REG_WR && (REG_ADDR == `SBCCT_OFS_CMP_A_HI);
  wire wr_cmp_a_lo = REG_WR && (REG_ADDR == `SBCCT_OFS_CMP_A_LO);
  wire wr_cmp_b_hi = REG_WR && (REG_ADDR == `SBCCT_OFS_CMP_B_HI);
  wire wr_cmp_b_lo = REG_WR && (REG_ADDR == `SBCCT_OFS_CMP_B_LO);
  wire any_acc = REG_WR || REG_RD;
  wire acc_cap_a_lo = any_acc && (REG_ADDR == `SBCCT_OFS_CAP_A_LO);
  wire acc_cap_b_lo = any_acc && (REG_ADDR == `SBCCT_OFS_CAP_B_LO);
  wire acc_cmp_a_lo = any_acc && (REG_ADDR == `SBCCT_OFS_CMP_A_LO);
  wire acc_cmp_b_lo = any_acc && (REG_ADDR == `SBCCT_OFS_CMP_B_LO);
  wire acc_cnt_lo = any_acc && (REG_ADDR == `SBCCT_OFS_CNT_LO);
  // Either low counter byte written restarts the counter
  wire cnt_restart = REG_WR && ((REG_ADDR == `SBCCT_OFS_CNT_LO) || (REG_ADDR == `SBCCT_OFS_ALT_LO));

  // ============================================================
  // Modes; waveform mode wins over single pulse mode
  wire wave_on = ctrl_two[`SBCCT_C2_WAVE];
  wire single_on = ctrl_two[`SBCCT_C2_SINGLE] & ~wave_on;
  wire [1:0] clock_select = {ctrl_two[`SBCCT_C2_CLK_HI], ctrl_two[`SBCCT_C2_CLK_LO]};
  wire out_level_a = ctrl_one[`SBCCT_C1_LEVEL_A];
  wire out_level_b = ctrl_one[`SBCCT_C1_LEVEL_B];

  // ============================================================
  // Counting tick from prescaler or external pin
  wire ext_sel = (clock_select == `SBCCT_CLK_EXT);
  wire ext_edge = edge_seen(ext_prev, EXT_CLOCK_PIN, ctrl_two[`SBCCT_C2_EXT_EDGE]);
  wire presc_wrap = (presc >= presc_last(clock_select));
  // Counter only advances while not frozen; missing ext pin stops it
  wire tick = ~timer_freeze & (ext_sel ? (ext_edge & (EXT_CLOCK_PRESENT != 0)) : presc_wrap);

  // ============================================================
  // Capture edges
  wire cap_a_edge = edge_seen(cap_a_prev, CAPTURE_PIN_A, ctrl_one[`SBCCT_C1_EDGE_A]);
  wire cap_b_edge = edge_seen(cap_b_prev, CAPTURE_PIN_B, ctrl_two[`SBCCT_C2_EDGE_B]);
  // Pin A feeds the pulse trigger in single pulse mode and is cut off in waveform mode
  wire pulse_start = single_on & cap_a_edge;
  wire cap_a_event = cap_a_edge & ~single_on & ~wave_on;

  // ============================================================
  // Compare matches on the counter value being left by the tick
  wire match_a = tick & ~inhibit_a & (counter == active_cmp_a);
  wire match_b = tick & ~inhibit_b & (counter == active_cmp_b);
  wire period_end = wave_on & match_b;
  wire roll_event = tick & (counter == `SBCCT_CNT_TOP) & ~cnt_restart & ~pulse_start & ~period_end;

  // ============================================================
  // Flag set terms
  wire set_cap_a = cap_a_event | pulse_start | period_end;
  wire set_cmp_a = match_a & ~wave_on & ~single_on;
  wire set_cmp_b = match_b & ~wave_on;
  wire set_cap_b = cap_b_edge;
  wire [4:0] flag_vec = {capture_a_flag, compare_a_flag, rollover_flag, capture_b_flag, compare_b_flag};
  wire [4:0] low_access = {acc_cap_a_lo, acc_cmp_a_lo, acc_cnt_lo, acc_cap_b_lo, acc_cmp_b_lo};
  wire [4:0] clear_now = clear_armed & low_access;

  // ============================================================
  // Control, freeze and compare registers
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ctrl_one <= `SBCCT_CTRL_RESET;
      ctrl_two <= `SBCCT_CTRL_RESET;
      timer_freeze <= 1'b0;
      compare_value_a <= `SBCCT_CMP_RESET;
      compare_value_b <= `SBCCT_CMP_RESET;
      inhibit_a <= 1'b0;
      inhibit_b <= 1'b0;
    end else begin
      if (wr_c1) begin
        ctrl_one <= REG_WDATA;
      end
      if (wr_c2) begin
        ctrl_two <= REG_WDATA;
      end
      if (wr_st) begin
        timer_freeze <= REG_WDATA[`SBCCT_ST_FREEZE];
      end
      // High byte write holds off matching until the low byte follows
      if (wr_cmp_a_hi) begin
        compare_value_a[15:8] <= REG_WDATA;
        inhibit_a <= 1'b1;
      end
      if (wr_cmp_a_lo) begin
        compare_value_a[7:0] <= REG_WDATA;
        inhibit_a <= 1'b0;
      end
      if (wr_cmp_b_hi) begin
        compare_value_b[15:8] <= REG_WDATA;
        inhibit_b <= 1'b1;
      end
      if (wr_cmp_b_lo) begin
        compare_value_b[7:0] <= REG_WDATA;
        inhibit_b <= 1'b0;
      end
    end
  end

  // ============================================================
  // Values used for matching; in waveform mode they move only at period end
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      active_cmp_a <= `SBCCT_CMP_RESET;
      active_cmp_b <= `SBCCT_CMP_RESET;
    end else if (!wave_on || period_end) begin
      active_cmp_a <= compare_value_a;
      active_cmp_b <= compare_value_b;
    end
  end

  // ============================================================
  // Prescaler and counter
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      presc <= 3'h0;
      counter <= `SBCCT_CNT_RELOAD;
    end else begin
      // Prescaler holds while frozen
      if (!timer_freeze) begin
        presc <= presc_wrap ? 3'h0 : presc + 3'h1;
      end
      if (cnt_restart || pulse_start) begin
        counter <= `SBCCT_CNT_RELOAD;
      end else if (period_end) begin
        counter <= `SBCCT_CNT_RELOAD;
      end else if (tick) begin
        counter <= counter + 16'h0001;
      end
    end
  end

  // ============================================================
  // Capture registers keep their value until the next capture
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      capture_value_a <= 16'h0000;
      capture_value_b <= 16'h0000;
      cap_a_prev <= 1'b0;
      cap_b_prev <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      cap_a_prev <= CAPTURE_PIN_A;
      cap_b_prev <= CAPTURE_PIN_B;
      ext_prev <= EXT_CLOCK_PIN;
      if (cap_a_event) begin
        capture_value_a <= counter;
      end
      if (cap_b_edge) begin
        capture_value_b <= counter;
      end
    end
  end

  // ============================================================
  // Flags: status read arms the clear, low byte access performs it, set wins
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      capture_a_flag <= 1'b0;
      compare_a_flag <= 1'b0;
      rollover_flag <= 1'b0;
      capture_b_flag <= 1'b0;
      compare_b_flag <= 1'b0;
      clear_armed <= 5'h00;
    end else begin
      capture_a_flag <= set_cap_a | (capture_a_flag & ~clear_now[4]);
      compare_a_flag <= set_cmp_a | (compare_a_flag & ~clear_now[3]);
      rollover_flag <= roll_event | (rollover_flag & ~clear_now[2]);
      capture_b_flag <= set_cap_b | (capture_b_flag & ~clear_now[1]);
      compare_b_flag <= set_cmp_b | (compare_b_flag & ~clear_now[0]);
      if (rd_st) begin
        clear_armed <= flag_vec;
      end else begin
        clear_armed <= clear_armed & ~clear_now & flag_vec;
      end
    end
  end

  // ============================================================
  // Output levels driven by matches, modes and force bits
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      level_a <= 1'b0;
      level_b <= 1'b0;
    end else begin
      if (wr_c1 && REG_WDATA[`SBCCT_C1_FORCE_A]) begin
        level_a <= REG_WDATA[`SBCCT_C1_LEVEL_A];
      end else if ((wave_on && period_end) || pulse_start) begin
        level_a <= out_level_b;
      end else if (match_a && (wave_on || single_on)) begin
        level_a <= out_level_a;
      end else if (match_a) begin
        level_a <= out_level_a;
      end
      if (wr_c1 && REG_WDATA[`SBCCT_C1_FORCE_B]) begin
        level_b <= REG_WDATA[`SBCCT_C1_LEVEL_B];
      end else if (match_b && !wave_on && !single_on) begin
        level_b <= out_level_b;
      end
    end
  end

  // ============================================================
  // Pins: enables route the levels, freeze takes both pins away
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      COMPARE_PIN_A <= 1'b0;
      COMPARE_PIN_B <= 1'b0;
      COMPARE_PIN_A_OE <= 1'b0;
      COMPARE_PIN_B_OE <= 1'b0;
    end else begin
      COMPARE_PIN_A <= level_a;
      COMPARE_PIN_B <= level_b;
      COMPARE_PIN_A_OE <= ctrl_two[`SBCCT_C2_PIN_A_EN] & ~timer_freeze;
      COMPARE_PIN_B_OE <= ctrl_two[`SBCCT_C2_PIN_B_EN] & ~timer_freeze;
    end
  end

  // ============================================================
  // Shared interrupt request
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      TIMER_IRQ <= 1'b0;
    end else begin
      TIMER_IRQ <= ~CPU_IRQ_MASK &
        (((capture_a_flag | capture_b_flag) & ctrl_one[`SBCCT_C1_CAP_IE]) |
         ((compare_a_flag | compare_b_flag) & ctrl_one[`SBCCT_C1_CMP_IE]) |
         (rollover_flag & ctrl_one[`SBCCT_C1_ROLL_IE]));
    end
  end

  // ============================================================
  // Read data, one cycle after the strobe, zero otherwise
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `SBCCT_OFS_CTRL_TWO: REG_RDATA <= ctrl_two;
        `SBCCT_OFS_CTRL_ONE: REG_RDATA <= ctrl_one;
        `SBCCT_OFS_STATUS: REG_RDATA <= {flag_vec, timer_freeze, 2'b00};
        `SBCCT_OFS_CAP_A_HI: REG_RDATA <= capture_value_a[15:8];
        `SBCCT_OFS_CAP_A_LO: REG_RDATA <= capture_value_a[7:0];
        `SBCCT_OFS_CMP_A_HI: REG_RDATA <= compare_value_a[15:8];
        `SBCCT_OFS_CMP_A_LO: REG_RDATA <= compare_value_a[7:0];
        `SBCCT_OFS_CNT_HI: REG_RDATA <= counter[15:8];
        `SBCCT_OFS_CNT_LO: REG_RDATA <= counter[7:0];
        `SBCCT_OFS_ALT_HI: REG_RDATA <= counter[15:8];
        `SBCCT_OFS_ALT_LO: REG_RDATA <= counter[7:0];
        `SBCCT_OFS_CAP_B_HI: REG_RDATA <= capture_value_b[15:8];
        `SBCCT_OFS_CAP_B_LO: REG_RDATA <= capture_value_b[7:0];
        `SBCCT_OFS_CMP_B_HI: REG_RDATA <= compare_value_b[15:8];
        `SBCCT_OFS_CMP_B_LO: REG_RDATA <= compare_value_b[7:0];
        default: REG_RDATA <= 8'h00;
      endcase
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

endmodule

// ---- bench/sbcct_asserts.sv ----
// Checker of the timer's register port, pins and request line
`timescale 1ns/1ps
module sbcct_asserts (
  input wire REF_CLK,
  input wire SYS_RST,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_RDATA,
  input wire CPU_IRQ_MASK,
  input wire TIMER_IRQ,
  input wire COMPARE_PIN_A,
  input wire COMPARE_PIN_A_OE,
  input wire COMPARE_PIN_B,
  input wire COMPARE_PIN_B_OE
);
  // ============================================================
  // Clocking and bus steps
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  sequence wr_at(logic [7:0] a);
    REG_WR && REG_ADDR == a;
  endsequence
  sequence rd_at(logic [7:0] a);
    REG_RD && REG_ADDR == a;
  endsequence
  // ============================================================
  // Properties
  chk_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data not idle");
  chk_rdata_unmapped: assert property ($past(REG_RD) && $past(REG_ADDR) < 8'h51 |-> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  chk_status_rsvd: assert property (rd_at(8'h53) |=> REG_RDATA[1:0] == 2'h0)
    else $error("status low bits set");
  chk_ctrl_readback: assert property (wr_at(8'h52) ##1 rd_at(8'h52) |=> REG_RDATA == $past(REG_WDATA, 2))
    else $error("control readback wrong");
  chk_freeze_oe: assert property (wr_at(8'h53) ##0 REG_WDATA[2] |-> ##[1:2] !COMPARE_PIN_A_OE && !COMPARE_PIN_B_OE)
    else $error("pins driven while frozen");
  chk_pin_a_off: assert property (wr_at(8'h51) ##0 !REG_WDATA[7] |-> ##[1:2] !COMPARE_PIN_A_OE)
    else $error("pin A driven while disabled");
  chk_irq_masked: assert property ($past(CPU_IRQ_MASK) |-> !TIMER_IRQ)
    else $error("request while masked");
  chk_force_a: assert property (wr_at(8'h52) ##0 REG_WDATA[3] |-> ##2 COMPARE_PIN_A == $past(REG_WDATA[0], 2))
    else $error("force A level wrong");
  chk_force_b: assert property (wr_at(8'h52) ##0 REG_WDATA[4] |-> ##2 COMPARE_PIN_B == $past(REG_WDATA[2], 2))
    else $error("force B level wrong");
endmodule

bind sbcct_timer sbcct_asserts i_chk (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CPU_IRQ_MASK(CPU_IRQ_MASK),
  .TIMER_IRQ(TIMER_IRQ), .COMPARE_PIN_A(COMPARE_PIN_A), .COMPARE_PIN_A_OE(COMPARE_PIN_A_OE),
  .COMPARE_PIN_B(COMPARE_PIN_B), .COMPARE_PIN_B_OE(COMPARE_PIN_B_OE));

// ---- bench/sbcct_pins.sv ----
// Pin-side model: two capture pins and the external count clock
`timescale 1ns/1ps
module sbcct_pins (
  input wire clk,
  input wire ext_run,
  output reg cap_a,
  output reg cap_b,
  output reg ext_clk
);
  reg [1:0] ph;
  initial begin
    cap_a = 1'b0;
    cap_b = 1'b0;
    ext_clk = 1'b0;
    ph = 2'h0;
  end
  // External clock toggles every third cycle while running, stands still otherwise
  always @(posedge clk) begin
    if (ext_run) begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      if (ph == 2'h2) ext_clk <= ~ext_clk;
    end
  end
  // Move one capture pin to a level and hold it a few cycles
  task set_pin(input ch, input lvl);
    begin
      @(posedge clk);
      if (ch) cap_b <= lvl;
      else cap_a <= lvl;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule

// ---- bench/test_sixteen_bit_capture_compare_timer.sv ----
// Self-checking bench of the capture/compare timer
`timescale 1ns/1ps
module test_sixteen_bit_capture_compare_timer;
  reg REF_CLK, SYS_RST, REG_WR, REG_RD, CPU_IRQ_MASK, ext_run, pv, cur, rd_pend;
  reg [7:0] REG_ADDR, REG_WDATA;
  wire [7:0] REG_RDATA;
  wire TIMER_IRQ, COMPARE_PIN_A, COMPARE_PIN_A_OE, COMPARE_PIN_B, COMPARE_PIN_B_OE, cap_a, cap_b, ext_clk;
  logic [15:0] notes[$];
  logic [15:0] n;
  logic [7:0] v, w, fl;
  int num_errors, checks_done, i, k, e, t;
  sbcct_timer #(.EXT_CLOCK_PRESENT(1)) i_dut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CAPTURE_PIN_A(cap_a),
    .CAPTURE_PIN_B(cap_b), .EXT_CLOCK_PIN(ext_clk), .CPU_IRQ_MASK(CPU_IRQ_MASK), .TIMER_IRQ(TIMER_IRQ),
    .COMPARE_PIN_A(COMPARE_PIN_A), .COMPARE_PIN_A_OE(COMPARE_PIN_A_OE), .COMPARE_PIN_B(COMPARE_PIN_B),
    .COMPARE_PIN_B_OE(COMPARE_PIN_B_OE));
  sbcct_pins i_pins (.clk(REF_CLK), .ext_run(ext_run), .cap_a(cap_a), .cap_b(cap_b), .ext_clk(ext_clk));
  // ============================================================
  // Clock
  initial begin
    REF_CLK = 1'b0;
    forever #10 REF_CLK = ~REF_CLK;
  end
  // ============================================================
  // Compare and report tasks
  task conclude;
    begin
      $display("Checks %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task fail(input [7:0] got, input [7:0] exp);
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cmp_byte(input [7:0] got, input [7:0] exp);
    begin
      checks_done++;
      if (got !== exp) fail(got, exp);
    end
  endtask
  task cmp_bit(input got, input exp);
    begin
      cmp_byte({7'h00, got}, {7'h00, exp});
    end
  endtask
  task cmp_near(input [7:0] got, input [7:0] exp, input [7:0] tol);
    begin
      checks_done++;
      if (!((got - exp) <= tol || (exp - got) <= tol)) fail(got, exp);
    end
  endtask
  // ============================================================
  // Bus and pin tasks; strobes stay up until the next task sets them
  task wr(input [7:0] a, input [7:0] d);
    begin
      REG_WR <= 1'b1;
      REG_RD <= 1'b0;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge REF_CLK);
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp, input [7:0] m);
    begin
      REG_RD <= 1'b1;
      REG_WR <= 1'b0;
      REG_ADDR <= a;
      notes.push_back({m, exp});
      @(posedge REF_CLK);
    end
  endtask
  task cyc(input int c);
    begin
      REG_WR <= 1'b0;
      REG_RD <= 1'b0;
      repeat (c) @(posedge REF_CLK);
    end
  endtask
  task rdv(input [7:0] a, output [7:0] r);
    begin
      rd(a, 8'h00, 8'h00);
      cyc(1);
      r = REG_RDATA;
    end
  endtask
  task pin(input ch, input lvl);
    begin
      cyc(1);
      i_pins.set_pin(ch, lvl);
    end
  endtask
  task waitfor(input sel, input lvl);
    begin
      cyc(0);
      t = 0;
      while (((sel ? COMPARE_PIN_A : TIMER_IRQ) !== lvl) && t < 300) begin
        @(posedge REF_CLK);
        t++;
      end
      cmp_bit(t < 300, 1'b1);
      if (t >= 300) conclude;
    end
  endtask
  // Read result monitor: oldest note against the answer cycle
  always @(posedge REF_CLK) begin
    if (rd_pend) begin
      n = notes.pop_front();
      if (n[15:8] != 8'h00) cmp_byte(REG_RDATA & n[15:8], n[7:0] & n[15:8]);
    end
    rd_pend <= REG_RD;
  end
  // ============================================================
  // Main sequence
  initial begin
    {SYS_RST, REG_WR, REG_RD, CPU_IRQ_MASK, ext_run, rd_pend} = 6'h20;
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    num_errors = 0;
    checks_done = 0;
    w = $urandom(32'h2fff3b05);
    repeat (4) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    @(posedge REF_CLK);
    rd(8'h53, 8'h00, 8'hff);
    rd(8'h58, 8'hff, 8'hff);
    rd(8'h59, 8'hfc, 8'hfc);
    rd(8'h51, 8'h00, 8'hff);
    rd(8'h52, 8'h00, 8'hff);
    rd(8'h56, 8'h80, 8'hff);
    rd(8'h5f, 8'h00, 8'hff);
    rd(8'h50, 8'h00, 8'hff);
    $display("reset values done");
    for (i = 0; i < 4; i++) begin
      w = $urandom;
      wr(8'h52, w);
      rd(8'h52, w, 8'hff);
    end
    wr(8'h51, w & 8'h0f);
    rd(8'h51, w & 8'h0f, 8'hff);
    wr(8'h53, 8'hfb);
    rd(8'h53, 8'h00, 8'h07);
    wr(8'h51, 8'hc0);
    for (k = 0; k < 2; k++) begin
      wr(8'h52, {3'h0, 2'h3, k[0], 1'b0, k[0]});
      cyc(3);
      cmp_bit(COMPARE_PIN_A, k[0]);
      cmp_bit(COMPARE_PIN_B, k[0]);
      cmp_bit(COMPARE_PIN_A_OE & COMPARE_PIN_B_OE, 1'b1);
    end
    wr(8'h53, 8'h04);
    wr(8'h59, 8'h00);
    cyc(30);
    cmp_bit(COMPARE_PIN_A_OE | COMPARE_PIN_B_OE, 1'b0);
    rd(8'h59, 8'hfc, 8'hff);
    rd(8'h53, 8'h04, 8'h07);
    $display("control, force and freeze done");
    for (k = 0; k < 3; k++) begin
      wr(8'h51, {4'h0, k[1:0], 2'h0});
      wr(8'h59, 8'h00);
      wr(8'h53, 8'h00);
      cyc(48);
      wr(8'h53, 8'h04);
      rdv(8'h59, v);
      cmp_near(v, 8'hfc + (k == 0 ? 8'h0c : k == 1 ? 8'h18 : 8'h06), 8'h02);
    end
    for (e = 0; e < 2; e++) begin
      wr(8'h51, {6'h03, 1'b0, e[0]});
      wr(8'h59, 8'h00);
      wr(8'h53, 8'h00);
      cyc(1);
      ext_run <= 1'b1;
      pv = ext_clk;
      t = 0;
      for (i = 0; i < 64; i++) begin
        @(posedge REF_CLK);
        cur = ext_clk;
        if (cur !== pv && cur === e[0]) t++;
        pv = cur;
        if (i == 58) ext_run <= 1'b0;
      end
      wr(8'h53, 8'h04);
      rdv(8'h59, v);
      cmp_byte(v, 8'hfc + t[7:0]);
    end
    $display("clock selection done");
    wr(8'h51, 8'h04);
    wr(8'h52, 8'h20);
    rd(8'h53, 8'h00, 8'h00);
    rd(8'h59, 8'h00, 8'h00);
    CPU_IRQ_MASK <= 1'b1;
    wr(8'h59, 8'h00);
    wr(8'h53, 8'h00);
    cyc(30);
    cmp_bit(TIMER_IRQ, 1'b0);
    CPU_IRQ_MASK <= 1'b0;
    waitfor(1'b0, 1'b1);
    rd(8'h53, 8'h20, 8'h20);
    rd(8'h5b, 8'h00, 8'h00);
    rd(8'h53, 8'h20, 8'h20);
    rd(8'h59, 8'h00, 8'h00);
    rd(8'h53, 8'h00, 8'h20);
    cyc(3);
    cmp_bit(TIMER_IRQ, 1'b0);
    $display("rollover done");
    for (k = 0; k < 2; k++) begin
      for (e = 0; e < 2; e++) begin
        fl = k ? 8'h10 : 8'h80;
        if (k == 0) wr(8'h52, {6'h20, e[0], 1'b0});
        else wr(8'h51, {6'h01, e[0], 1'b0});
        pin(k[0], e[0]);
        rd(8'h53, 8'h00, 8'h00);
        rd(k ? 8'h5d : 8'h55, 8'h00, 8'h00);
        pin(k[0], ~e[0]);
        rd(8'h53, 8'h00, fl);
        cyc(1);
        cmp_bit(TIMER_IRQ, 1'b0);
        pin(k[0], e[0]);
        cmp_bit(TIMER_IRQ, 1'b1);
        rd(8'h53, fl, fl);
        rdv(k ? 8'h5d : 8'h55, v);
        rdv(8'h59, w);
        cmp_near(w - v, 8'h06, 8'h06);
        rd(8'h53, 8'h00, fl);
        cyc(2);
        cmp_bit(TIMER_IRQ, 1'b0);
      end
    end
    $display("captures done");
    wr(8'h51, 8'h84);
    wr(8'h52, 8'h08);
    wr(8'h52, 8'h01);
    wr(8'h56, 8'h00);
    wr(8'h57, 8'h10);
    wr(8'h5e, 8'h00);
    wr(8'h5f, 8'h12);
    rd(8'h53, 8'h00, 8'h00);
    rd(8'h57, 8'h00, 8'h00);
    rd(8'h5f, 8'h00, 8'h00);
    wr(8'h59, 8'h00);
    waitfor(1'b1, 1'b1);
    cyc(10);
    cmp_bit(COMPARE_PIN_B_OE, 1'b0);
    rd(8'h53, 8'h48, 8'h48);
    rd(8'h57, 8'h10, 8'hff);
    rd(8'h5f, 8'h12, 8'hff);
    rd(8'h53, 8'h00, 8'h48);
    $display("compare done");
    wr(8'h52, 8'h84);
    rd(8'h53, 8'h00, 8'h00);
    rd(8'h55, 8'h00, 8'h00);
    wr(8'h51, 8'h94);
    wr(8'h59, 8'h00);
    for (i = 0; i < 2; i++) begin
      waitfor(1'b1, 1'b1);
      waitfor(1'b1, 1'b0);
    end
    rd(8'h53, 8'h80, 8'hc8);
    waitfor(1'b0, 1'b1);
    cyc(2);
    $display("waveform done");
    wr(8'h51, 8'ha4);
    pin(1'b0, 1'b0);
    cmp_bit(COMPARE_PIN_A, 1'b1);
    waitfor(1'b1, 1'b0);
    $display("single pulse done");
    conclude;
  end
endmodule
